// ===== logic/mport_regs_params.svh
// Constants for the crossbar master port register bank.
// Assumes a big-endian bit numbering in software views; logic uses [31:0].
// Overview of operation
// - Lock-transfer enable bit permits locked transfers when 1; resets to 1.
// - Read pipelining enable; clearable directly or by setting early-end mode.
// - Write pipelining forced 0 while posting off; also cleared by early-end mode.
// - Posting off: line or burst transfer raises crossbar interrupt flag 17.
// - Failed transaction captures upper 4 and lower 32 address bits.
// - Any write to status clears it and both address registers.
// - With capture hold set, status updates only while valid is 0.
// - Valid bit reads 1 after a capture, 0 when nothing captured.
// - Requester field codes 0 to 4; origin bit meaningful for codes 3, 4.
// - Slave size 00/01/10, 11 marks address timeout; type only 000.
// - Status also captures lock error, read flag, size and byte enables.
// - Misc status bits clear on write 1; feed interrupt bits 17 and 24.
// - Posting fault bit 0 set on line or burst with posting off.
// - Early-end fault bit 1 set on early termination when unsupported.
// - Bits 18 to 31 are overflow/underflow pairs for seven queues.
// - Latched slave interrupt forces all requester bits to read 1.
// - Slave write error with posting on sets requester bit until cleared.
// - Requester bits 19 to 31 map to DMA, processor and slave masters.
// - Flush mode 00 automatic timeout flush, 11 no flush; resets 00.
// - Writing 1 to bits 25 to 31 resets a queue; reads as 0.
// - Sniffer watches for described command at address, reports via capture.
// - State-machine state register reads all zeros.
// - Capture hold bit 0 locks status and address registers; resets 1.
// - Sniffer bit 0 enables capture; per-field enables gate matching.
// - Sniffer address register holds lower 32 address bits to match.
`ifndef MPORT_REGS_PARAMS_SVH
`define MPORT_REGS_PARAMS_SVH
`define ADDR_CONFIG 8'h54
`define ADDR_FAIL_UPPER 8'h56
`define ADDR_FAIL_LOWER 8'h57
`define ADDR_FAIL_STATUS 8'h58
`define ADDR_MISC_STATUS 8'h59
`define ADDR_ERR_INT 8'h5a
`define ADDR_SM_STATES 8'h5b
`define ADDR_MISC_CONTROL 8'h5c
`define ADDR_SNIFF_CMD 8'h5d
`define ADDR_SNIFF_ADDR 8'h5e
// Big-endian bit n maps to logic bit 31-n
`define CFG_RESET 32'h8000_009f
`define CFG_HOLD 31
`define CFG_ETERM 5
`define CFG_LOCKED_TRANSFER_ENABLE 4
`define CFG_READ_ADDR_PIPELINE_ENABLE 3
`define CFG_WRITE_ADDR_PIPELINE_ENABLE 2
`define CFG_POSTED_WRITE_ENABLE 1
`define CFG_KEEP1 0
`define CFG_WMASK 32'h8000_00ff
`define MISC_CTL_WMASK 32'h6000_0000
`define FLUSH_LSB 29
`define QCLR_MASK 32'h0000_007f
`define MS_POSTING 31
`define MS_EARLY 30
`define MS_QUEUE_MASK 32'h0000_3fff
`define EI_MASK 32'h0000_1fff
`define EI_DMA0 12
`define EI_CPU0 10
`define EI_SP0 7
`define EI_SP1 3
`define SN_ENABLE 31
`define SN_SIZE_LSB 24
`define SN_RNW 23
`define SN_MID_LSB 20
`define SN_ORIGIN 19
`define SN_SPMID_LSB 16
`define SN_SSIZE_LSB 14
`define SN_SIZE_EN 6
`define SN_RNW_EN 5
`define SN_MID_EN 4
`define SN_ORIGIN_EN 3
`define SN_SPMID_EN 2
`define SN_SSIZE_EN 1
`define SN_ADDR_EN 0
`define MID_SLAVE0 3'h3
`define MID_SLAVE1 3'h4
`define SSIZE_TIMEOUT 2'h3
`define TYPE_MEMORY 3'h0
`endif

// ===== logic/mport_regs_pkg.sv
// Types for the master port register bank.
// Assumes the params header is compiled alongside.
package mport_regs_pkg;
  typedef enum logic [1:0] {
    FLUSH_AUTO = 2'h0,
    FLUSH_RSVD1 = 2'h1,
    FLUSH_RSVD2 = 2'h2,
    FLUSH_NONE = 2'h3
  } flush_mode_t;
endpackage : mport_regs_pkg

// ===== logic/sniff_match.sv
// Sniffer comparator: matches one observed command against the sniffer setup.
// Assumes command qualifiers are valid in the cycle cmd_valid_i is high.
`timescale 1ns/1ps
`include "mport_regs_params.svh"
module sniff_match
  import mport_regs_pkg::*;
(
  // Sniffer setup
  input wire logic [31:0] sniff_cmd_i,
  input wire logic [31:0] sniff_addr_i,
  // Observed command
  input wire logic cmd_valid_i,
  input wire logic [31:0] cmd_addr_i,
  input wire logic [3:0] cmd_size_i,
  input wire logic cmd_rnw_i,
  input wire logic [2:0] cmd_mid_i,
  input wire logic cmd_origin_i,
  input wire logic [1:0] cmd_spmid_i,
  input wire logic [1:0] cmd_ssize_i,
  // Result
  output logic hit_o
);
  logic ok_size, ok_rnw, ok_mid, ok_org, ok_spmid, ok_ssize, ok_addr;
  // Each disabled field is a don't-care
  always_comb
  begin
    ok_size = !sniff_cmd_i[`SN_SIZE_EN] ||
      sniff_cmd_i[`SN_SIZE_LSB +: 4] == cmd_size_i;
    ok_rnw = !sniff_cmd_i[`SN_RNW_EN] || sniff_cmd_i[`SN_RNW] == cmd_rnw_i;
    ok_mid = !sniff_cmd_i[`SN_MID_EN] ||
      sniff_cmd_i[`SN_MID_LSB +: 3] == cmd_mid_i;
    ok_org = !sniff_cmd_i[`SN_ORIGIN_EN] ||
      sniff_cmd_i[`SN_ORIGIN] == cmd_origin_i;
    ok_spmid = !sniff_cmd_i[`SN_SPMID_EN] ||
      sniff_cmd_i[`SN_SPMID_LSB +: 2] == cmd_spmid_i;
    ok_ssize = !sniff_cmd_i[`SN_SSIZE_EN] ||
      sniff_cmd_i[`SN_SSIZE_LSB +: 2] == cmd_ssize_i;
    ok_addr = !sniff_cmd_i[`SN_ADDR_EN] || sniff_addr_i == cmd_addr_i;
    hit_o = cmd_valid_i && sniff_cmd_i[`SN_ENABLE] && ok_size && ok_rnw &&
      ok_mid && ok_org && ok_spmid && ok_ssize && ok_addr;
  end
endmodule : sniff_match

// ===== logic/mport_regs.sv
// Master port configuration, error capture and status register bank.
// Assumes register port and event inputs are synchronous to clock_i.
`timescale 1ns/1ps
`include "mport_regs_params.svh"
module mport_regs
  import mport_regs_pkg::*;
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // Register port
  input wire logic reg_read_i,
  input wire logic reg_write_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  output logic [31:0] reg_rdata_o,
  output logic reg_ack_o,
  // Observed command and failure events
  input wire logic cmd_valid_i,
  input wire logic cmd_fail_i,
  input wire logic cmd_multi_i,
  input wire logic early_end_i,
  input wire logic [3:0] cmd_addr_high_i,
  input wire logic [31:0] cmd_addr_i,
  input wire logic cmd_lock_err_i,
  input wire logic cmd_origin_i,
  input wire logic [2:0] cmd_mid_i,
  input wire logic [1:0] cmd_spmid_i,
  input wire logic [1:0] cmd_ssize_i,
  input wire logic [2:0] cmd_type_i,
  input wire logic cmd_rnw_i,
  input wire logic [3:0] cmd_size_i,
  input wire logic [15:0] cmd_be_i,
  // Slave error inputs
  input wire logic slave_irq_i,
  input wire logic slave_wr_err_i,
  // Queue faults, one per status bit 18..31
  input wire logic [13:0] queue_fault_i,
  // Configuration outputs
  output logic locked_transfer_enable_o,
  output logic read_addr_pipeline_enable_o,
  output logic write_addr_pipeline_enable_o,
  output logic posted_write_enable_o,
  output logic slave_early_end_support_o,
  output flush_mode_t flush_mode_o,
  output logic [6:0] queue_clear_o,
  // Crossbar interrupt status feeds
  output logic int_config_fault_o,
  output logic int_queue_fault_o
);
  logic [31:0] master_port_config, next_master_port_config;
  logic [3:0] fail_address_upper, next_fail_address_upper;
  logic [31:0] fail_address_lower, next_fail_address_lower;
  logic [31:0] fail_qualifier_status, next_fail_qualifier_status;
  logic [31:0] master_misc_status, next_master_misc_status;
  logic [12:0] err_int_sticky, next_err_int_sticky;
  logic [1:0] flush_field, next_flush_field;
  logic [6:0] queue_clear, next_queue_clear;
  logic [31:0] sniffer_command, next_sniffer_command;
  logic [31:0] sniffer_match_address, next_sniffer_match_address;
  logic [31:0] reg_rdata, next_reg_rdata;
  logic reg_ack, next_reg_ack;
  logic sniff_hit;
  logic capture;
  logic [12:0] requester_bit;
  logic [31:0] error_interrupt_status;

  // Returns a one-hot requester position for a write error
  function automatic logic [12:0] requester_onehot(
    input logic [2:0] mid,
    input logic origin,
    input logic [1:0] spmid
  );
    logic [12:0] r;
    r = 13'h0000;
    unique case (mid)
      3'h0: r[`EI_CPU0] = 1'b1;
      3'h1: r[`EI_CPU0 - 1] = 1'b1;
      3'h2: r[`EI_CPU0 - 2] = 1'b1;
      `MID_SLAVE0:
        if (origin)
          r[`EI_SP0 - spmid] = 1'b1;
        else
          r[`EI_DMA0] = 1'b1;
      `MID_SLAVE1:
        if (origin)
          r[`EI_SP1 - spmid] = 1'b1;
        else
          r[`EI_DMA0 - 1] = 1'b1;
      default: r = 13'h0000;
    endcase
    return r;
  endfunction : requester_onehot

  function automatic logic hit_write(input logic [7:0] a);
    return reg_write_i && reg_addr_i == a;
  endfunction : hit_write

  sniff_match u_sniff (
    .sniff_cmd_i(sniffer_command),
    .sniff_addr_i(sniffer_match_address),
    .cmd_valid_i(cmd_valid_i),
    .cmd_addr_i(cmd_addr_i),
    .cmd_size_i(cmd_size_i),
    .cmd_rnw_i(cmd_rnw_i),
    .cmd_mid_i(cmd_mid_i),
    .cmd_origin_i(cmd_origin_i),
    .cmd_spmid_i(cmd_spmid_i),
    .cmd_ssize_i(cmd_ssize_i),
    .hit_o(sniff_hit)
  );

  // Error-interrupt view: latched slave request overrides sticky bits
  always_comb
  begin
    requester_bit = requester_onehot(cmd_mid_i, cmd_origin_i, cmd_spmid_i);
    error_interrupt_status = {19'h0_0000, err_int_sticky};
    if (slave_irq_i)
      error_interrupt_status = `EI_MASK;
  end

  // Capture happens on failure or sniff hit, unless held
  always_comb
  begin
    capture = (cmd_fail_i || sniff_hit) &&
      !(master_port_config[`CFG_HOLD] && fail_qualifier_status[31]);
  end

  // Next-state for all registers
  always_comb
  begin
    next_master_port_config = master_port_config;
    next_fail_address_upper = fail_address_upper;
    next_fail_address_lower = fail_address_lower;
    next_fail_qualifier_status = fail_qualifier_status;
    next_master_misc_status = master_misc_status;
    next_err_int_sticky = err_int_sticky;
    next_flush_field = flush_field;
    next_queue_clear = 7'h00;
    next_sniffer_command = sniffer_command;
    next_sniffer_match_address = sniffer_match_address;
    next_reg_ack = reg_read_i || reg_write_i;
    next_reg_rdata = 32'h0000_0000;

    // Configuration write, then hardware-forced clears
    if (hit_write(`ADDR_CONFIG))
      next_master_port_config = reg_wdata_i & `CFG_WMASK;
    if (next_master_port_config[`CFG_ETERM])
    begin
      next_master_port_config[`CFG_READ_ADDR_PIPELINE_ENABLE] = 1'b0;
      next_master_port_config[`CFG_WRITE_ADDR_PIPELINE_ENABLE] = 1'b0;
    end
    if (!next_master_port_config[`CFG_POSTED_WRITE_ENABLE])
      next_master_port_config[`CFG_WRITE_ADDR_PIPELINE_ENABLE] = 1'b0;

    // Capture registers: a write clears them, a later event refills
    if (hit_write(`ADDR_FAIL_STATUS))
    begin
      next_fail_qualifier_status = 32'h0000_0000;
      next_fail_address_upper = 4'h0;
      next_fail_address_lower = 32'h0000_0000;
    end
    else if (capture)
    begin
      next_fail_address_upper = cmd_addr_high_i;
      next_fail_address_lower = cmd_addr_i;
      next_fail_qualifier_status = {1'b1, cmd_lock_err_i, cmd_origin_i,
        cmd_mid_i, cmd_ssize_i, cmd_type_i, cmd_rnw_i, cmd_size_i,
        cmd_be_i};
    end

    // Misc status: write-one clears, new events win
    if (hit_write(`ADDR_MISC_STATUS))
      next_master_misc_status = master_misc_status & ~reg_wdata_i;
    if (cmd_valid_i && cmd_multi_i && !master_port_config[`CFG_POSTED_WRITE_ENABLE])
      next_master_misc_status[`MS_POSTING] = 1'b1;
    if (early_end_i && !master_port_config[`CFG_ETERM])
      next_master_misc_status[`MS_EARLY] = 1'b1;
    next_master_misc_status[13:0] =
      next_master_misc_status[13:0] | queue_fault_i;

    // Sticky requester bits from posted write errors
    if (hit_write(`ADDR_ERR_INT))
      next_err_int_sticky = err_int_sticky & ~reg_wdata_i[12:0];
    if (slave_wr_err_i && master_port_config[`CFG_POSTED_WRITE_ENABLE])
      next_err_int_sticky = next_err_int_sticky | requester_bit;

    // Misc control: flush field and self-clearing queue resets
    if (hit_write(`ADDR_MISC_CONTROL))
    begin
      next_flush_field = reg_wdata_i[`FLUSH_LSB +: 2];
      next_queue_clear = reg_wdata_i[6:0];
    end
    if (hit_write(`ADDR_SNIFF_CMD))
      next_sniffer_command = reg_wdata_i;
    if (hit_write(`ADDR_SNIFF_ADDR))
      next_sniffer_match_address = reg_wdata_i;

    // Read mux; unmapped and write-only locations return zero
    if (reg_read_i)
    begin
      unique case (reg_addr_i)
        `ADDR_CONFIG: next_reg_rdata = master_port_config;
        `ADDR_FAIL_UPPER: next_reg_rdata = {28'h000_0000, fail_address_upper};
        `ADDR_FAIL_LOWER: next_reg_rdata = fail_address_lower;
        `ADDR_FAIL_STATUS: next_reg_rdata = fail_qualifier_status;
        `ADDR_MISC_STATUS: next_reg_rdata = master_misc_status;
        `ADDR_ERR_INT: next_reg_rdata = error_interrupt_status;
        `ADDR_SM_STATES: next_reg_rdata = 32'h0000_0000;
        `ADDR_MISC_CONTROL:
          next_reg_rdata = {1'b0, flush_field, 29'h0000_0000};
        `ADDR_SNIFF_CMD: next_reg_rdata = sniffer_command;
        `ADDR_SNIFF_ADDR: next_reg_rdata = sniffer_match_address;
        default: next_reg_rdata = 32'h0000_0000;
      endcase
    end
  end

  // Register all state; synchronous reset
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      master_port_config <= `CFG_RESET;
      fail_address_upper <= 4'h0;
      fail_address_lower <= 32'h0000_0000;
      fail_qualifier_status <= 32'h0000_0000;
      master_misc_status <= 32'h0000_0000;
      err_int_sticky <= 13'h0000;
      flush_field <= 2'h0;
      queue_clear <= 7'h00;
      sniffer_command <= 32'h0000_0000;
      sniffer_match_address <= 32'h0000_0000;
      reg_rdata <= 32'h0000_0000;
      reg_ack <= 1'b0;
    end
    else
    begin
      master_port_config <= next_master_port_config;
      fail_address_upper <= next_fail_address_upper;
      fail_address_lower <= next_fail_address_lower;
      fail_qualifier_status <= next_fail_qualifier_status;
      master_misc_status <= next_master_misc_status;
      err_int_sticky <= next_err_int_sticky;
      flush_field <= next_flush_field;
      queue_clear <= next_queue_clear;
      sniffer_command <= next_sniffer_command;
      sniffer_match_address <= next_sniffer_match_address;
      reg_rdata <= next_reg_rdata;
      reg_ack <= next_reg_ack;
    end
  end

  // Outputs from flip-flops; the two interrupt feeds are ORs of status flops
  always_comb
  begin
    reg_rdata_o = reg_rdata;
    reg_ack_o = reg_ack;
    locked_transfer_enable_o = master_port_config[`CFG_LOCKED_TRANSFER_ENABLE];
    read_addr_pipeline_enable_o = master_port_config[`CFG_READ_ADDR_PIPELINE_ENABLE];
    write_addr_pipeline_enable_o = master_port_config[`CFG_WRITE_ADDR_PIPELINE_ENABLE];
    posted_write_enable_o = master_port_config[`CFG_POSTED_WRITE_ENABLE];
    slave_early_end_support_o = master_port_config[`CFG_ETERM];
    flush_mode_o = flush_mode_t'(flush_field);
    queue_clear_o = queue_clear;
    // Level feeds for the crossbar interrupt status bits
    int_config_fault_o = master_misc_status[`MS_POSTING] ||
      master_misc_status[`MS_EARLY];
    int_queue_fault_o = |(master_misc_status & `MS_QUEUE_MASK);
  end
endmodule : mport_regs

// ===== verification/mport_regs_monitor.sv
// Checker for the master port register bank, bound to its top ports.
// Assumes one clock domain and the synchronous active-high reset.
`timescale 1ns/1ps
`include "mport_regs_params.svh"
module mport_regs_monitor
  import mport_regs_pkg::*;
(
  // Clock, reset and register port
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic reg_read_i,
  input wire logic reg_write_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic reg_ack_o,
  // Events
  input wire logic cmd_valid_i,
  input wire logic cmd_multi_i,
  input wire logic early_end_i,
  input wire logic [13:0] queue_fault_i,
  // Configuration and status outputs
  input wire logic locked_transfer_enable_o,
  input wire logic read_addr_pipeline_enable_o,
  input wire logic write_addr_pipeline_enable_o,
  input wire logic posted_write_enable_o,
  input wire logic slave_early_end_support_o,
  input flush_mode_t flush_mode_o,
  input wire logic [6:0] queue_clear_o,
  input wire logic int_config_fault_o,
  input wire logic int_queue_fault_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  // Register handshake: one answer per strobe, data zero between
  chk_ack_follows: assert property ((reg_read_i || reg_write_i) |=> reg_ack_o)
    else $error("ack missing after strobe");
  chk_ack_cause: assert property (reg_ack_o |-> $past(reg_read_i || reg_write_i))
    else $error("ack without strobe");
  chk_rdata_idle: assert property (!reg_ack_o |-> reg_rdata_o == 32'h0000_0000)
    else $error("read data not zero when idle");
  // Enable interlocks; one cycle of slack after a write
  chk_write_addr_pipeline_enable_gated: assert property (!posted_write_enable_o &&
    $past(!posted_write_enable_o) |-> !write_addr_pipeline_enable_o)
    else $error("write pipelining on without posting");
  chk_eterm_pipes: assert property (slave_early_end_support_o &&
    $past(slave_early_end_support_o) |-> !read_addr_pipeline_enable_o &&
    !write_addr_pipeline_enable_o) else $error("pipelining on in early end");
  // Fault flags reach the interrupt feeds within two cycles
  chk_posting_flag: assert property (cmd_valid_i && cmd_multi_i &&
    !posted_write_enable_o |-> ##[1:2] int_config_fault_o)
    else $error("posting fault not flagged");
  chk_early_flag: assert property (early_end_i &&
    !slave_early_end_support_o |-> ##[1:2] int_config_fault_o)
    else $error("early end fault not flagged");
  chk_queue_flag: assert property (|queue_fault_i |->
    ##[1:2] int_queue_fault_o) else $error("queue fault not flagged");
  chk_qclear_cause: assert property (queue_clear_o != 7'h00 |->
    $past(reg_write_i && reg_addr_i == `ADDR_MISC_CONTROL) &&
    queue_clear_o == $past(reg_wdata_i[6:0])) else $error("bad queue clear");
  chk_reset_values: assert property ($fell(rst_i) |->
    locked_transfer_enable_o && flush_mode_o == FLUSH_AUTO)
    else $error("wrong enable or flush after reset");
  // Main scenarios reached
  cov_config_fault: cover property (int_config_fault_o);
  cov_queue_clear: cover property (queue_clear_o != 7'h00);
  cov_read: cover property (reg_ack_o && reg_read_i);
endmodule : mport_regs_monitor

bind mport_regs mport_regs_monitor u_mon (.clock_i, .rst_i, .reg_read_i,
  .reg_write_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .reg_ack_o,
  .cmd_valid_i, .cmd_multi_i, .early_end_i, .queue_fault_i,
  .locked_transfer_enable_o, .read_addr_pipeline_enable_o,
  .write_addr_pipeline_enable_o, .posted_write_enable_o,
  .slave_early_end_support_o, .flush_mode_o, .queue_clear_o,
  .int_config_fault_o, .int_queue_fault_o);

// ===== verification/slave_side_model.sv
// Model of a bus slave: write error pulse and latched interrupt.
// Assumes go_i is a one-cycle request from the bench.
`timescale 1ns/1ps
module slave_side_model (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // Bench controls
  input wire logic go_i,
  input wire logic slow_i,
  input wire logic irq_req_i,
  // Slave outputs
  output logic slave_wr_err_o,
  output logic slave_irq_o
);
  logic [2:0] wait_count;
  logic [2:0] next_wait_count;
  // Error answers promptly or after a few cycles
  always_comb
  begin
    next_wait_count = (wait_count != 3'h0) ? wait_count - 3'h1 : 3'h0;
    if (go_i)
      next_wait_count = slow_i ? 3'h4 : 3'h1;
  end
  // Interrupt stays latched until the bench drops it
  always_ff @(posedge clock_i)
  begin
    wait_count <= rst_i ? 3'h0 : next_wait_count;
    slave_wr_err_o <= !rst_i && wait_count == 3'h1;
    slave_irq_o <= !rst_i && irq_req_i;
  end
endmodule : slave_side_model

// ===== verification/mport_regs_test.sv
// Self-checking bench for the master port register bank.
// Assumes the checker is bound by its own file.
`timescale 1ns/1ps
`include "mport_regs_params.svh"
module mport_regs_test
  import mport_regs_pkg::*;
;
  logic clock_i = 0, rst_i = 1, reg_read_i = 0, reg_write_i = 0;
  logic [7:0] reg_addr_i = 0;
  logic [31:0] reg_wdata_i = 0, cmd_addr_i = 0, reg_rdata_o;
  logic cmd_valid_i = 0, cmd_fail_i = 0, cmd_multi_i = 0, early_end_i = 0;
  logic cmd_lock_err_i = 0, cmd_origin_i = 0, cmd_rnw_i = 0;
  logic [3:0] cmd_addr_high_i = 0, cmd_size_i = 0;
  logic [2:0] cmd_mid_i = 0, cmd_type_i = 0;
  logic [1:0] cmd_spmid_i = 0, cmd_ssize_i = 0;
  logic [15:0] cmd_be_i = 0;
  logic [13:0] queue_fault_i = 0;
  logic go = 0, slow = 0, irq_req = 0, slave_irq_i, slave_wr_err_i;
  logic reg_ack_o, locked_transfer_enable_o, read_addr_pipeline_enable_o;
  logic write_addr_pipeline_enable_o, posted_write_enable_o;
  logic slave_early_end_support_o, int_config_fault_o, int_queue_fault_o;
  flush_mode_t flush_mode_o;
  logic [6:0] queue_clear_o;
  int failures = 0, comparisons = 0, cycles = 0;
  mport_regs dut (.clock_i, .rst_i, .reg_read_i, .reg_write_i, .reg_addr_i,
    .reg_wdata_i, .reg_rdata_o, .reg_ack_o, .cmd_valid_i, .cmd_fail_i,
    .cmd_multi_i, .early_end_i, .cmd_addr_high_i, .cmd_addr_i,
    .cmd_lock_err_i, .cmd_origin_i, .cmd_mid_i, .cmd_spmid_i, .cmd_ssize_i,
    .cmd_type_i, .cmd_rnw_i, .cmd_size_i, .cmd_be_i, .slave_irq_i,
    .slave_wr_err_i, .queue_fault_i, .locked_transfer_enable_o,
    .read_addr_pipeline_enable_o, .write_addr_pipeline_enable_o,
    .posted_write_enable_o, .slave_early_end_support_o, .flush_mode_o,
    .queue_clear_o, .int_config_fault_o, .int_queue_fault_o);
  slave_side_model u_slave (.clock_i, .rst_i, .go_i(go), .slow_i(slow),
    .irq_req_i(irq_req), .slave_wr_err_o(slave_wr_err_i),
    .slave_irq_o(slave_irq_i));
  // Clock and hang guard; the ceiling is well above the run length
  initial forever #5 clock_i = ~clock_i;
  always @(posedge clock_i)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      failures++;
      print_verdict();
    end
  end
  task automatic check(logic [31:0] seen, logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      failures++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // Strobe one cycle; answer lands on the following edge
  task automatic access(logic w, logic [7:0] a, logic [31:0] d);
    @(posedge clock_i) #1;
    {reg_read_i, reg_write_i, reg_addr_i, reg_wdata_i} = {!w, w, a, d};
    @(posedge clock_i) #1;
    {reg_read_i, reg_write_i} = 2'b00;
  endtask : access
  task automatic wr(logic [7:0] a, logic [31:0] d);
    access(1'b1, a, d);
  endtask : wr
  task automatic rd(logic [7:0] a, logic [31:0] e);
    access(1'b0, a, 32'h0000_0000);
    check(reg_rdata_o, e);
  endtask : rd
  // One-cycle event: valid, fail, multi, early end
  task automatic ev(logic [3:0] k);
    @(posedge clock_i) #1;
    {cmd_valid_i, cmd_fail_i, cmd_multi_i, early_end_i} = k;
    @(posedge clock_i) #1;
    {cmd_valid_i, cmd_fail_i, cmd_multi_i, early_end_i} = 4'h0;
  endtask : ev
  function automatic logic [31:0] st(logic lk, logic o, logic [2:0] m,
    logic [1:0] s, logic r, logic [3:0] z, logic [15:0] b);
    return {1'b1, lk, o, m, s, 3'h0, r, z, b};
  endfunction : st
  task automatic t_reset;
    logic [7:0] a;
    rd(`ADDR_CONFIG, 32'h8000_009f);
    check(locked_transfer_enable_o, 1);
    check(posted_write_enable_o, 1);
    for (a = 8'h56; a <= 8'h5c; a++)
      rd(a, 32'h0000_0000);
    rd(`ADDR_SNIFF_ADDR, 32'h0000_0000);
    rd(8'h60, 32'h0000_0000);
  endtask : t_reset
  task automatic t_config;
    wr(`ADDR_CONFIG, 32'h8000_009d);
    rd(`ADDR_CONFIG, 32'h8000_0099);
    check(posted_write_enable_o, 0);
    check(write_addr_pipeline_enable_o, 0);
    ev(4'ha);
    rd(`ADDR_MISC_STATUS, 32'h8000_0000);
    check(int_config_fault_o, 1);
    wr(`ADDR_MISC_STATUS, 32'h8000_0000);
    rd(`ADDR_MISC_STATUS, 32'h0000_0000);
    wr(`ADDR_CONFIG, 32'h8000_00bf);
    rd(`ADDR_CONFIG, 32'h8000_00b3);
    check(read_addr_pipeline_enable_o, 0);
    check(slave_early_end_support_o, 1);
    ev(4'h1);
    rd(`ADDR_MISC_STATUS, 32'h0000_0000);
    wr(`ADDR_CONFIG, 32'h8000_009f);
    ev(4'h1);
    rd(`ADDR_MISC_STATUS, 32'h4000_0000);
    wr(`ADDR_MISC_STATUS, 32'hffff_ffff);
  endtask : t_config
  task automatic t_capture;
    {cmd_addr_high_i, cmd_addr_i, cmd_lock_err_i, cmd_origin_i} =
      {4'ha, 32'h1234_5678, 2'b11};
    {cmd_mid_i, cmd_ssize_i, cmd_rnw_i, cmd_size_i, cmd_be_i} =
      {3'h3, 2'h2, 1'b1, 4'h5, 16'hf0f0};
    ev(4'h4);
    rd(`ADDR_FAIL_STATUS, st(1, 1, 3'h3, 2'h2, 1, 4'h5, 16'hf0f0));
    rd(`ADDR_FAIL_UPPER, 32'h0000_000a);
    rd(`ADDR_FAIL_LOWER, 32'h1234_5678);
    {cmd_mid_i, cmd_addr_i} = {3'h0, 32'h0000_0000};
    ev(4'h4);
    rd(`ADDR_FAIL_LOWER, 32'h1234_5678);
    wr(`ADDR_FAIL_STATUS, 32'h0000_0000);
    rd(`ADDR_FAIL_STATUS, 32'h0000_0000);
    rd(`ADDR_FAIL_UPPER, 32'h0000_0000);
    wr(`ADDR_CONFIG, 32'h0000_009f);
    ev(4'h4);
    {cmd_mid_i, cmd_ssize_i} = {3'h2, 2'h3};
    ev(4'h4);
    rd(`ADDR_FAIL_STATUS, st(1, 1, 3'h2, 2'h3, 1, 4'h5, 16'hf0f0));
  endtask : t_capture
  task automatic t_sniff;
    wr(`ADDR_FAIL_STATUS, 32'h0000_0000);
    wr(`ADDR_SNIFF_ADDR, 32'h0000_1000);
    wr(`ADDR_SNIFF_CMD, 32'h80a0_0031);
    rd(`ADDR_SNIFF_CMD, 32'h80a0_0031);
    {cmd_addr_i, cmd_rnw_i} = {32'h0000_1000, 1'b0};
    ev(4'h8);
    rd(`ADDR_FAIL_STATUS, 32'h0000_0000);
    cmd_rnw_i = 1;
    ev(4'h8);
    rd(`ADDR_FAIL_LOWER, 32'h0000_1000);
    wr(`ADDR_SNIFF_CMD, 32'h0000_0000);
  endtask : t_sniff
  task automatic t_queue;
    @(posedge clock_i) #1 queue_fault_i = 14'h2001;
    @(posedge clock_i) #1 queue_fault_i = 14'h0001;
    wr(`ADDR_MISC_STATUS, 32'h0000_0001); // Clear collides with set
    queue_fault_i = 14'h0000;
    rd(`ADDR_MISC_STATUS, 32'h0000_2001);
    check(int_queue_fault_o, 1);
    wr(`ADDR_MISC_STATUS, 32'h0000_2000);
    rd(`ADDR_MISC_STATUS, 32'h0000_0001);
    wr(`ADDR_MISC_STATUS, 32'h0000_0001);
    check(int_queue_fault_o, 0);
  endtask : t_queue
  task automatic t_control;
    wr(`ADDR_MISC_CONTROL, 32'hffff_ffff);
    check(queue_clear_o, 7'h7f);
    check(flush_mode_o, FLUSH_NONE);
    rd(`ADDR_MISC_CONTROL, 32'h6000_0000);
    wr(`ADDR_MISC_CONTROL, 32'h0000_0001);
    check(queue_clear_o, 7'h01);
    check(flush_mode_o, FLUSH_AUTO);
  endtask : t_control
  // Slave write error from a given requester, slow or prompt
  task automatic err(logic s, logic [2:0] m, logic o, logic [1:0] p);
    {slow, cmd_mid_i, cmd_origin_i, cmd_spmid_i} = {s, m, o, p};
    @(posedge clock_i) #1 go = 1;
    @(posedge clock_i) #1 go = 0;
    repeat (6) @(posedge clock_i);
  endtask : err
  task automatic t_irq;
    err(0, 3'h1, 0, 2'h0);
    rd(`ADDR_ERR_INT, 32'h0000_0200);
    wr(`ADDR_ERR_INT, 32'h0000_0200);
    err(1, 3'h3, 1, 2'h2);
    rd(`ADDR_ERR_INT, 32'h0000_0020);
    wr(`ADDR_ERR_INT, 32'h0000_0020);
    err(0, 3'h4, 0, 2'h0);
    rd(`ADDR_ERR_INT, 32'h0000_0800);
    wr(`ADDR_ERR_INT, 32'h0000_0800);
    wr(`ADDR_CONFIG, 32'h8000_008d);
    check(locked_transfer_enable_o, 0);
    err(0, 3'h1, 0, 2'h0);
    rd(`ADDR_ERR_INT, 32'h0000_0000);
    irq_req = 1;
    rd(`ADDR_ERR_INT, 32'h0000_1fff);
    irq_req = 0;
    repeat (2) @(posedge clock_i);
    rd(`ADDR_ERR_INT, 32'h0000_0000);
  endtask : t_irq
  task automatic print_verdict;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict
  // Main sequence after six reset cycles
  initial
  begin
    repeat (6) @(posedge clock_i);
    #1 rst_i = 0;
    t_reset();
    t_config();
    t_capture();
    t_sniff();
    t_queue();
    t_control();
    t_irq();
    print_verdict();
  end
endmodule : mport_regs_test
